// ### secf_pkg.sv
// shared constants and types for the serial eeprom command front end
package secf_pkg;

	localparam int SYS_CLK_HZ   = 50_000_000;
	localparam int MEM_ADDR_W   = 16;
	localparam int PAGE_BYTES   = 128;
	localparam int PAGE_IDX_W   = 7;
	localparam int SECTOR_OFS_W = 14;
	localparam int TIMER_W      = 20;
	localparam int RX_BUF_DEPTH = 2;
	// worst-case cycles from chip select high until the decoder is idle
	localparam int END_DRAIN_CYC = 8;

	localparam logic [7:0] READ_CMD              = 8'h03;
	localparam logic [7:0] WRITE_CMD             = 8'h02;
	localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
	localparam logic [7:0] PAGE_ERASE_CMD        = 8'h42;
	localparam logic [7:0] SECTOR_ERASE_CMD      = 8'hd8;
	localparam logic [7:0] CHIP_ERASE_CMD        = 8'hc7;
	localparam logic [7:0] WAKE_AND_SIGNATURE_CMD = 8'hab;
	localparam logic [7:0] DEEP_SLEEP_CMD        = 8'hb9;

	localparam logic [7:0]  ERASED_BYTE = 8'hff;
	localparam logic [15:0] ADDR_LAST   = 16'hffff;
	localparam logic [15:0] ADDR_FIRST  = 16'h0000;
	// arbitrary neutral signature value
	localparam logic [7:0]  SIGNATURE_DEF = 8'h5a;

	localparam int CHIP_ERASE_TIME_MS        = 10;
	localparam int SECTOR_ERASE_TIME_MS      = 10;
	localparam int WRITE_CYCLE_TIME_MS       = 5;
	localparam int STANDBY_ENTRY_TIME_US     = 100;
	localparam int DEEP_SLEEP_ENTRY_TIME_US  = 100;
	localparam int CYC_PER_MS = SYS_CLK_HZ / 1000;
	localparam int CYC_PER_US = SYS_CLK_HZ / 1_000_000;
	// longest times, so rounding down
	localparam int CHIP_ERASE_CYC_DEF   = CHIP_ERASE_TIME_MS * CYC_PER_MS;
	localparam int SECTOR_ERASE_CYC_DEF = SECTOR_ERASE_TIME_MS * CYC_PER_MS;
	localparam int WRITE_CYCLE_CYC_DEF  = WRITE_CYCLE_TIME_MS * CYC_PER_MS;
	localparam int STANDBY_ENTRY_CYC_DEF = STANDBY_ENTRY_TIME_US * CYC_PER_US;
	localparam int DEEP_SLEEP_ENTRY_CYC_DEF =
		DEEP_SLEEP_ENTRY_TIME_US * CYC_PER_US;

	typedef enum logic [2:0] {
		CMD_OPCODE, CMD_ADDR_HI, CMD_ADDR_LO, CMD_DATA, CMD_DONE, CMD_SKIP
	} secf_cmd_st_t;

	typedef enum logic [1:0] {
		TX_NONE, TX_MEM, TX_STATUS, TX_SIG
	} secf_tx_src_t;

	typedef enum logic [3:0] {
		ACT_NONE, ACT_LATCH_SET, ACT_LATCH_CLR, ACT_PAGE_WR, ACT_STAT_WR,
		ACT_ERASE_PAGE, ACT_ERASE_SECT, ACT_ERASE_CHIP, ACT_SLEEP, ACT_WAKE
	} secf_act_t;

	typedef enum logic [1:0] {
		ENG_IDLE, ENG_COMMIT, ENG_FILL
	} secf_eng_st_t;

	typedef struct packed {
		logic       guard_en;
		logic [2:0] unused;
		logic [1:0] protect;
		logic       latch;
		logic       busy;
	} secf_status_t;

endpackage

// ### secf_pair_buf.sv
// small valid/ready buffer between the bit shifter and the decoder
`timescale 1ns/10ps
module secf_pair_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             sys_clk,   // system clock
	input  wire logic             rst_n,     // sync reset, active low
	input  wire logic             in_valid,  // source offers a word
	input  wire logic [WIDTH-1:0] in_data,   // offered word
	output logic                  in_ready,  // room for a word
	output logic                  out_valid, // word available
	output logic      [WIDTH-1:0] out_data,  // oldest word
	input  wire logic             out_ready  // sink takes the word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] slot [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	if (DEPTH < 2) begin : g_chk
		$error("secf_pair_buf needs at least two entries");
	end

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = slot[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			slot[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
					: wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
					: rd_ptr_reg + AW'(1);
			end
			if (push && !pop) begin
				count_reg <= count_reg + (AW+1)'(1);
			end else if (pop && !push) begin
				count_reg <= count_reg - (AW+1)'(1);
			end
		end
	end
endmodule

// ### secf_cycle_timer.sv
// down counter that times the self-timed write and erase cycles
`timescale 1ns/10ps
module secf_cycle_timer import secf_pkg::*; #(
	parameter int W = TIMER_W
) (
	input  wire logic         sys_clk,  // system clock
	input  wire logic         rst_n,    // sync reset, active low
	input  wire logic         load,     // start a cycle
	input  wire logic [W-1:0] load_val, // cycle length in clocks
	output logic              busy      // cycle still running
);
	logic [W-1:0] cnt_reg;

	if (W < 2) begin : g_chk
		$error("secf_cycle_timer width too small");
	end

	assign busy = (cnt_reg != '0);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= load_val;
		end else if (busy) begin
			cnt_reg <= cnt_reg - W'(1);
		end
	end
endmodule

// ### secf_top.sv
// serial eeprom front end: shifter, decoder, array and self-timed engine
`timescale 1ns/10ps
module secf_top import secf_pkg::*; #(
	parameter int         CHIP_ERASE_CYC   = CHIP_ERASE_CYC_DEF,
	parameter int         SECTOR_ERASE_CYC = SECTOR_ERASE_CYC_DEF,
	parameter int         WRITE_CYCLE_CYC  = WRITE_CYCLE_CYC_DEF,
	parameter int         STANDBY_CYC      = STANDBY_ENTRY_CYC_DEF,
	parameter int         DEEP_SLEEP_CYC   = DEEP_SLEEP_ENTRY_CYC_DEF,
	parameter logic [7:0] SIGNATURE        = SIGNATURE_DEF
) (
	input  wire logic sys_clk,                // system clock, 50 MHz
	input  wire logic rst_n,                  // sync reset, active low
	input  wire logic spi_sck,                // serial clock from host
	input  wire logic spi_cs_n,               // chip select, active low
	input  wire logic spi_si,                 // serial data in
	input  wire logic spi_hold_n,             // pause input, active low
	output logic      spi_so,                 // serial data out
	output logic      spi_so_oe,              // data out driven
	output logic      write_in_progress_flag, // self-timed cycle busy
	output logic      write_latch_flag,       // write latch state
	output logic      deep_sleep_flag         // in deep power-down
);
	localparam logic [TIMER_W-1:0] T_CHIP  = TIMER_W'(CHIP_ERASE_CYC);
	localparam logic [TIMER_W-1:0] T_SECT  = TIMER_W'(SECTOR_ERASE_CYC);
	localparam logic [TIMER_W-1:0] T_WRITE = TIMER_W'(WRITE_CYCLE_CYC);

	if (CHIP_ERASE_CYC < 1 || CHIP_ERASE_CYC >= (1 << TIMER_W) ||
	    SECTOR_ERASE_CYC < 1 || SECTOR_ERASE_CYC >= (1 << TIMER_W) ||
	    WRITE_CYCLE_CYC < 1 || WRITE_CYCLE_CYC >= (1 << TIMER_W)) begin : g_t
		$error("secf_top cycle time out of timer range");
	end
	if (STANDBY_CYC < END_DRAIN_CYC ||
	    DEEP_SLEEP_CYC < END_DRAIN_CYC) begin : g_p
		$error("secf_top power-mode entry shorter than frame drain");
	end

	logic [7:0]      mem_array [2**MEM_ADDR_W];
	logic [7:0]      page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_mask_reg;

	logic            sck_prev_reg;
	logic            cs_prev_reg;
	logic [2:0]      bit_cnt_reg;
	logic [6:0]      rx_sh_reg;
	logic [7:0]      rx_byte_reg;
	logic            rx_pend_reg;
	logic            rx_ready;
	logic            buf_valid;
	logic [7:0]      buf_data;
	logic            dec_ready;
	logic            take;

	secf_cmd_st_t    cmd_st_reg;
	secf_tx_src_t    tx_src_reg;
	logic [7:0]      cmd_reg;
	logic [15:0]     addr_reg;
	logic [7:0]      stat_new_reg;
	logic            got_data_reg;
	logic            fetch_wait_reg;
	logic            end_pend_reg;
	logic            end_aligned_reg;
	logic            frame_end;
	secf_act_t       act;

	logic [15:0]     rd_ptr_reg;
	logic [7:0]      mem_q_reg;
	logic [7:0]      tx_sh_reg;
	logic [7:0]      tx_byte;
	logic            tx_started_reg;
	logic            tx_load;

	secf_status_t    status;
	logic            guard_en_reg;
	logic [1:0]      protect_reg;
	logic            busy;
	logic            tmr_busy;
	logic            tmr_load;
	logic [TIMER_W-1:0] tmr_val;
	secf_eng_st_t    eng_st_reg;
	logic [15:0]     eng_addr_reg;
	logic [15:0]     eng_last_reg;

	wire sck_rise = spi_sck & ~sck_prev_reg;
	wire sck_fall = ~spi_sck & sck_prev_reg;
	wire cs_rise  = spi_cs_n & ~cs_prev_reg;
	wire live     = ~spi_cs_n & spi_hold_n;

	// first state after an opcode; sleep and busy narrow what is accepted
	function automatic secf_cmd_st_t first_state(input logic [7:0] op,
	                                             input logic sleeping,
	                                             input logic cyc_busy);
		secf_cmd_st_t st;
		st = CMD_SKIP;
		if (sleeping) begin
			if (op == WAKE_AND_SIGNATURE_CMD) begin
				st = CMD_ADDR_HI;
			end
		end else if (cyc_busy) begin
			if (op == STATUS_READ_CMD) begin
				st = CMD_DATA;
			end
		end else begin
			case (op)
				READ_CMD, WRITE_CMD, PAGE_ERASE_CMD, SECTOR_ERASE_CMD,
				WAKE_AND_SIGNATURE_CMD: st = CMD_ADDR_HI;
				STATUS_READ_CMD, STATUS_WRITE_CMD: st = CMD_DATA;
				SET_WRITE_LATCH_CMD, CLEAR_WRITE_LATCH_CMD, CHIP_ERASE_CMD,
				DEEP_SLEEP_CMD: st = CMD_DONE;
				default: st = CMD_SKIP;
			endcase
		end
		return st;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sck_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b1;
		end else begin
			sck_prev_reg <= spi_sck;
			cs_prev_reg  <= spi_cs_n;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bit_cnt_reg <= 3'h0;
			rx_sh_reg   <= 7'h00;
			rx_byte_reg <= 8'h00;
			rx_pend_reg <= 1'b0;
		end else begin
			if (rx_pend_reg && rx_ready) begin
				rx_pend_reg <= 1'b0;
			end
			if (spi_cs_n) begin
				bit_cnt_reg <= 3'h0;
			end else if (spi_hold_n && sck_rise) begin
				rx_sh_reg   <= {rx_sh_reg[5:0], spi_si};
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7) begin
					rx_byte_reg <= {rx_sh_reg, spi_si};
					rx_pend_reg <= 1'b1;
				end
			end
		end
	end

	secf_pair_buf #(
		.WIDTH (8),
		.DEPTH (RX_BUF_DEPTH)
	) u_rx_buf (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (rx_pend_reg),
		.in_data   (rx_byte_reg),
		.in_ready  (rx_ready),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (dec_ready)
	);

	// one stall cycle lets the array fetch the new read address
	assign dec_ready = ~fetch_wait_reg;
	assign take      = buf_valid & dec_ready;
	assign frame_end = end_pend_reg & ~buf_valid & ~rx_pend_reg;
	assign busy      = tmr_busy | (eng_st_reg != ENG_IDLE);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmd_st_reg      <= CMD_OPCODE;
			tx_src_reg      <= TX_NONE;
			cmd_reg         <= 8'h00;
			addr_reg        <= 16'h0000;
			stat_new_reg    <= 8'h00;
			got_data_reg    <= 1'b0;
			fetch_wait_reg  <= 1'b0;
			end_pend_reg    <= 1'b0;
			end_aligned_reg <= 1'b0;
		end else begin
			fetch_wait_reg <= 1'b0;
			if (cs_rise) begin
				end_pend_reg    <= 1'b1;
				end_aligned_reg <= (bit_cnt_reg == 3'h0);
				tx_src_reg      <= TX_NONE;
			end
			if (take) begin
				case (cmd_st_reg)
					CMD_OPCODE: begin
						cmd_reg      <= buf_data;
						got_data_reg <= 1'b0;
						// unknown or refused opcodes skip to frame end
						cmd_st_reg <= first_state(buf_data, deep_sleep_flag,
							busy);
						if (buf_data == STATUS_READ_CMD &&
						    !deep_sleep_flag && !cs_rise) begin
							tx_src_reg <= TX_STATUS;
						end
					end
					// address high byte then low byte
					CMD_ADDR_HI: begin
						addr_reg[15:8] <= buf_data;
						cmd_st_reg     <= CMD_ADDR_LO;
					end
					CMD_ADDR_LO: begin
						addr_reg[7:0] <= buf_data;
						cmd_st_reg    <= (cmd_reg == READ_CMD ||
							cmd_reg == WRITE_CMD ||
							cmd_reg == WAKE_AND_SIGNATURE_CMD)
							? CMD_DATA : CMD_DONE;
						if (!cs_rise && cmd_reg == READ_CMD) begin
							tx_src_reg     <= TX_MEM;
							fetch_wait_reg <= 1'b1;
						end
						if (!cs_rise && cmd_reg == WAKE_AND_SIGNATURE_CMD) begin
							tx_src_reg <= TX_SIG;
						end
					end
					CMD_DATA: begin
						if (cmd_reg == WRITE_CMD) begin
							// page write wraps inside its page
							addr_reg[PAGE_IDX_W-1:0] <=
								addr_reg[PAGE_IDX_W-1:0] + 7'h01;
							got_data_reg <= 1'b1;
						end
						if (cmd_reg == STATUS_WRITE_CMD) begin
							stat_new_reg <= buf_data;
							got_data_reg <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end else if (frame_end) begin
				// back to idle standby a few clocks after select
				end_pend_reg <= 1'b0;
				cmd_st_reg   <= CMD_OPCODE;
			end
		end
	end

	// page buffer collects write data until the frame is accepted
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			page_mask_reg <= '0;
		end else if (take && cmd_st_reg == CMD_OPCODE &&
		             buf_data == WRITE_CMD) begin
			page_mask_reg <= '0;
		end else if (take && cmd_st_reg == CMD_DATA &&
		             cmd_reg == WRITE_CMD) begin
			page_mask_reg[addr_reg[PAGE_IDX_W-1:0]] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (take && cmd_st_reg == CMD_DATA && cmd_reg == WRITE_CMD) begin
			page_buf[addr_reg[PAGE_IDX_W-1:0]] <= buf_data;
		end
	end

	always_comb begin
		act = ACT_NONE;
		if (frame_end && end_aligned_reg && cmd_st_reg != CMD_OPCODE &&
		    cmd_st_reg != CMD_SKIP) begin
			case (cmd_reg)
				// latch set only on a clean byte boundary
				SET_WRITE_LATCH_CMD: act = ACT_LATCH_SET;
				CLEAR_WRITE_LATCH_CMD: act = ACT_LATCH_CLR;
				WRITE_CMD:
					if (got_data_reg && write_latch_flag) act = ACT_PAGE_WR;
				STATUS_WRITE_CMD:
					if (got_data_reg && write_latch_flag) act = ACT_STAT_WR;
				PAGE_ERASE_CMD:
					if (write_latch_flag) act = ACT_ERASE_PAGE;
				SECTOR_ERASE_CMD:
					if (write_latch_flag) act = ACT_ERASE_SECT;
				CHIP_ERASE_CMD:
					if (write_latch_flag) act = ACT_ERASE_CHIP;
				DEEP_SLEEP_CMD: act = ACT_SLEEP;
				WAKE_AND_SIGNATURE_CMD: act = ACT_WAKE;
				default: act = ACT_NONE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			write_latch_flag <= 1'b0;
		end else if (act == ACT_LATCH_SET) begin
			write_latch_flag <= 1'b1;
		// clear the latch, also consumed by any started cycle
		end else if (act != ACT_NONE && act != ACT_SLEEP &&
		             act != ACT_WAKE) begin
			write_latch_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			deep_sleep_flag <= 1'b0;
		// sleep entered one clock after the frame drains
		end else if (act == ACT_SLEEP) begin
			deep_sleep_flag <= 1'b1;
		end else if (act == ACT_WAKE) begin
			deep_sleep_flag <= 1'b0;
		end
	end

	// status write updates the nonvolatile bits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			guard_en_reg <= 1'b0;
			protect_reg  <= 2'h0;
		end else if (act == ACT_STAT_WR) begin
			guard_en_reg <= stat_new_reg[7];
			protect_reg  <= stat_new_reg[3:2];
		end
	end

	always_comb begin
		tmr_load = 1'b1;
		tmr_val  = T_WRITE;
		case (act)
			ACT_PAGE_WR, ACT_STAT_WR, ACT_ERASE_PAGE: tmr_val = T_WRITE;
			ACT_ERASE_SECT: tmr_val = T_SECT;
			ACT_ERASE_CHIP: tmr_val = T_CHIP;
			default: tmr_load = 1'b0;
		endcase
	end

	secf_cycle_timer #(
		.W (TIMER_W)
	) u_timer (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.load     (tmr_load),
		.load_val (tmr_val),
		.busy     (tmr_busy)
	);

	// array writer: one byte per clock, well inside the default cycle times
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			eng_st_reg   <= ENG_IDLE;
			eng_addr_reg <= ADDR_FIRST;
			eng_last_reg <= ADDR_FIRST;
		end else begin
			case (eng_st_reg)
				ENG_IDLE: begin
					eng_last_reg <= ADDR_LAST;
					if (act == ACT_PAGE_WR) begin
						eng_st_reg   <= ENG_COMMIT;
						eng_addr_reg <= {addr_reg[15:PAGE_IDX_W], 7'h00};
					end else if (act == ACT_ERASE_PAGE) begin
						eng_st_reg   <= ENG_FILL;
						eng_addr_reg <= {addr_reg[15:PAGE_IDX_W], 7'h00};
						eng_last_reg <= {addr_reg[15:PAGE_IDX_W], 7'h7f};
					end else if (act == ACT_ERASE_SECT) begin
						eng_st_reg   <= ENG_FILL;
						eng_addr_reg <= {addr_reg[15:SECTOR_OFS_W], 14'h0000};
						eng_last_reg <= {addr_reg[15:SECTOR_OFS_W], 14'h3fff};
					end else if (act == ACT_ERASE_CHIP) begin
						eng_st_reg   <= ENG_FILL;
						eng_addr_reg <= ADDR_FIRST;
					end
				end
				ENG_COMMIT: begin
					if (page_mask_reg[eng_addr_reg[PAGE_IDX_W-1:0]]) begin
						mem_array[eng_addr_reg] <=
							page_buf[eng_addr_reg[PAGE_IDX_W-1:0]];
					end
					eng_addr_reg[PAGE_IDX_W-1:0] <=
						eng_addr_reg[PAGE_IDX_W-1:0] + 7'h01;
					if (eng_addr_reg[PAGE_IDX_W-1:0] == 7'h7f) begin
						eng_st_reg <= ENG_IDLE;
					end
				end
				ENG_FILL: begin
					mem_array[eng_addr_reg] <= ERASED_BYTE;
					eng_addr_reg <= eng_addr_reg + 16'h0001;
					if (eng_addr_reg == eng_last_reg) begin
						eng_st_reg <= ENG_IDLE;
					end
				end
				default: eng_st_reg <= ENG_IDLE;
			endcase
		end
	end

	// busy while timer or writer runs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			write_in_progress_flag <= 1'b0;
		end else begin
			write_in_progress_flag <= busy;
		end
	end

	assign status = '{guard_en: guard_en_reg, unused: 3'h0,
		protect: protect_reg, latch: write_latch_flag,
		busy: write_in_progress_flag};

	always_ff @(posedge sys_clk) begin
		mem_q_reg <= mem_array[rd_ptr_reg];
	end

	assign tx_load = live & sck_fall & (tx_src_reg != TX_NONE) &
		(bit_cnt_reg == 3'h0);

	always_comb begin
		case (tx_src_reg)
			TX_MEM: tx_byte = mem_q_reg;
			TX_STATUS: tx_byte = status;
			TX_SIG: tx_byte = SIGNATURE;
			default: tx_byte = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_ptr_reg <= ADDR_FIRST;
		end else if (take && cmd_st_reg == CMD_ADDR_LO) begin
			rd_ptr_reg <= {addr_reg[15:8], buf_data};
		// advance per byte, wrapping naturally at the top
		end else if (tx_load && tx_src_reg == TX_MEM) begin
			rd_ptr_reg <= rd_ptr_reg + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tx_sh_reg      <= 8'h00;
			tx_started_reg <= 1'b0;
			spi_so         <= 1'b0;
			spi_so_oe      <= 1'b0;
		end else if (spi_cs_n) begin
			tx_started_reg <= 1'b0;
			spi_so_oe      <= 1'b0;
		// output released during pause, state kept
		end else if (!spi_hold_n) begin
			spi_so_oe <= 1'b0;
		end else begin
			spi_so_oe <= tx_started_reg | tx_load;
			// msb goes out first on the falling edge
			if (tx_load) begin
				tx_sh_reg      <= tx_byte;
				spi_so         <= tx_byte[7];
				tx_started_reg <= 1'b1;
			end else if (sck_fall && tx_started_reg) begin
				tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
				spi_so    <= tx_sh_reg[6];
			end
		end
	end
endmodule

// ### secf_host.sv
// spi host model for the front end, mode 0
`timescale 1ns/10ps
module secf_host (
	input  wire logic sys_clk, // system clock
	input  wire logic so,      // data from device
	output logic      sck,     // serial clock
	output logic      cs_n,    // chip select
	output logic      si,      // serial data
	output logic      hold_n   // pause, active low
);
	initial begin
		{sck, cs_n, si, hold_n} = 4'b0101;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic sel(input logic on);
		wt(16);
		cs_n = !on;
		// released line must not keep its last level
		si = !si;
	endtask
	task automatic xb(input logic [7:0] t, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			si = t[i];
			wt(8);
			if (i == 3) begin
				hold_n = 1'b0;
				sck = 1'b1;
				wt(8);
				sck = 1'b0;
				wt(8);
				hold_n = 1'b1;
				wt(8);
			end
			sck = 1'b1;
			r[i] = so;
			wt(8);
			sck = 1'b0;
		end
	endtask
endmodule

// ### secf_checker.sv
// port assertions for the serial eeprom front end
`timescale 1ns/10ps
module secf_checker import secf_pkg::*; #(
	parameter int CHIP_ERASE_CYC = CHIP_ERASE_CYC_DEF
) (
	input wire logic sys_clk,                // clock
	input wire logic rst_n,                  // reset
	input wire logic spi_sck,                // serial clock
	input wire logic spi_cs_n,               // select
	input wire logic spi_si,                 // data in
	input wire logic spi_hold_n,             // pause
	input wire logic spi_so,                 // data out
	input wire logic spi_so_oe,              // out enable
	input wire logic write_in_progress_flag, // busy
	input wire logic write_latch_flag,       // latch
	input wire logic deep_sleep_flag         // asleep
);
	// chip erase fill may outlast its timer
	localparam int BUSY_MAX = 65536 + CHIP_ERASE_CYC + 16;
	logic [19:0] busy_cnt_reg;
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !write_in_progress_flag)
			busy_cnt_reg <= '0;
		else
			busy_cnt_reg <= busy_cnt_reg + 20'h0_0001;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_oe_off;
		spi_cs_n || !spi_hold_n |=> !spi_so_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("data out driven while idle or paused");
	property p_so_hold;
		spi_so_oe && spi_sck && $past(spi_sck) |-> $stable(spi_so);
	endproperty
	a_so_hold: assert property (p_so_hold)
		else $error("data out moved while clock high");
	property p_latch_end;
		$rose(write_latch_flag) |-> spi_cs_n;
	endproperty
	a_latch_end: assert property (p_latch_end)
		else $error("latch set inside a frame");
	property p_busy_end;
		$rose(write_in_progress_flag) |-> spi_cs_n;
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("cycle started inside a frame");
	property p_busy_latch;
		$rose(write_in_progress_flag) |-> ##[0:8] !write_latch_flag;
	endproperty
	a_busy_latch: assert property (p_busy_latch)
		else $error("latch not cleared by cycle");
	property p_sleep_end;
		$changed(deep_sleep_flag) |-> spi_cs_n;
	endproperty
	a_sleep_end: assert property (p_sleep_end)
		else $error("sleep changed inside a frame");
	property p_frame_quiet;
		!spi_cs_n && !$past(spi_cs_n) |-> $stable(write_latch_flag);
	endproperty
	a_frame_quiet: assert property (p_frame_quiet)
		else $error("latch changed while selected");
	property p_busy_max;
		busy_cnt_reg <= BUSY_MAX;
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("self-timed cycle too long");
endmodule
bind secf_top secf_checker #(.CHIP_ERASE_CYC(CHIP_ERASE_CYC)) u_chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .spi_sck(spi_sck),
	.spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n),
	.spi_so(spi_so), .spi_so_oe(spi_so_oe),
	.write_in_progress_flag(write_in_progress_flag),
	.write_latch_flag(write_latch_flag),
	.deep_sleep_flag(deep_sleep_flag));

// ### tb.sv
// self-checking bench for the serial eeprom front end
`timescale 1ns/10ps
module tb;
	import secf_pkg::*;
	localparam int W = 200;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       sck, cs_n, si, hold_n, so, so_oe, busy_flag, latch_flag, dsl;
	wire        so_w = so_oe ? so : !so;
	logic [7:0] rx[$];
	logic [7:0] mem[int];
	logic [7:0] rnd = 8'h32;
	logic [7:0] d0, d1, sw;
	int         failures = 0;
	int         comparisons = 0;
	int         cyc = 0;
	always #10 sys_clk = !sys_clk;
	secf_host u_host (.sys_clk(sys_clk), .so(so_w), .sck(sck),
		.cs_n(cs_n), .si(si), .hold_n(hold_n));
	secf_top #(.CHIP_ERASE_CYC(W), .SECTOR_ERASE_CYC(W),
		.WRITE_CYCLE_CYC(W), .STANDBY_CYC(16), .DEEP_SLEEP_CYC(16)
	) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sck(sck),
		.spi_cs_n(cs_n), .spi_si(si), .spi_hold_n(hold_n), .spi_so(so),
		.spi_so_oe(so_oe), .write_in_progress_flag(busy_flag),
		.write_latch_flag(latch_flag), .deep_sleep_flag(dsl));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [7:0] rd(input int a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction
	task automatic chk(input string n, input logic [7:0] e, s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic frame(input logic [7:0] b[$]);
		logic [7:0] r;
		rx = {};
		u_host.sel(1'b1);
		foreach (b[i]) begin
			u_host.xb(b[i], r);
			rx.push_back(r);
		end
		u_host.sel(1'b0);
		u_host.wt(16);
	endtask
	task automatic busy(input int lim);
		int n;
		n = 0;
		chk("busy start", 8'h01, busy_flag);
		while (busy_flag !== 1'b0 && n <= lim) begin
			@(negedge sys_clk);
			n++;
		end
		chk("busy end", 8'h00, busy_flag);
		chk("latch", 8'h00, latch_flag);
	endtask
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 100000) begin
			failures++;
			complete_run;
		end
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("flags", 8'h00, {busy_flag, latch_flag, dsl});
		frame({8'h06});
		chk("latch", 8'h01, latch_flag);
		frame({8'h04});
		chk("latch", 8'h00, latch_flag);
		frame({8'h12, 8'h06});
		chk("latch", 8'h00, latch_flag);
		frame({8'h02, 8'h00, 8'h00, rnd});
		chk("busy", 8'h00, busy_flag);
		$display("latch test done");
		frame({8'h06});
		frame({8'hc7});
		busy(65536 + W + 16);
		d0 = lfsr(rnd);
		d1 = lfsr(d0);
		frame({8'h06});
		frame({8'h02, 8'hff, 8'hff, d0, d1});
		mem[16'hffff] = d0;
		mem[16'hff80] = d1;
		busy(W + 16);
		frame({8'h03, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00});
		for (int i = 0; i < 3; i++)
			chk("read", rd((65535 + i) % 65536), rx[3+i]);
		frame({8'h03, 8'hff, 8'h80, 8'h00});
		chk("read", rd(16'hff80), rx[3]);
		frame({8'h06});
		frame({8'h42, 8'hff, 8'h80});
		mem.delete();
		busy(W + 16);
		frame({8'h03, 8'hff, 8'hff, 8'h00});
		chk("read", rd(16'hffff), rx[3]);
		frame({8'h06});
		frame({8'hd8, 8'h40, 8'h00});
		busy(2**SECTOR_OFS_W + W + 16);
		$display("array test done");
		sw = lfsr(d1);
		frame({8'h06});
		frame({8'h01, sw});
		busy(W + 16);
		frame({8'h05, 8'h00});
		chk("status", {sw[7], 3'b000, sw[3:2], 2'b00}, rx[1]);
		frame({8'hb9});
		chk("sleep", 8'h01, dsl);
		frame({8'hab, 8'h00, 8'h00, 8'h00});
		chk("signature", SIGNATURE_DEF, rx[3]);
		chk("sleep", 8'h00, dsl);
		$display("status and sleep test done");
		complete_run;
	end
endmodule
